/* hdl/dpc_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
module dpc_decoder (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic sclClk,
	input wire logic sdaIn,
	input wire logic strapAddrPinLow,
	input wire logic strapAddrPinHigh,
	output logic sdaOut,
	output logic sdaOe,
	output logic [dpc_pkg::DATA_W-1:0] wiperLatch,
	output logic writeProtect,
	output logic memReadPower,
	output logic [dpc_pkg::ADDR_W-1:0] targetAddr,
	output logic addrValid
);
	import dpc_pkg::*;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	logic linkTgl_reg;
	logic linkBit_reg;
	logic [4:0] syncVec;
	logic sclS, sdaS, tglS;
	logic sclPrev_reg, sdaPrev_reg, tglPrev_reg;
	dpc_link_type ev;
	logic [2:0] settleCnt_reg;
	logic addrValid_reg;
	logic [ADDR_W-1:0] targetAddr_reg;
	dpc_state_type state_reg;
	logic [3:0] bitCnt_reg;
	logic [DATA_W-1:0] shift_reg;
	logic [DATA_W-1:0] rxByte;
	dpc_cmd_type cmdNow;
	dpc_cmd_type cmd_reg;
	logic [IDX_W-1:0] idx_reg;
	logic byteDone, ackSlot, instrDone, dataDone, addrMatch, dataAccepted;
	logic ackPend_reg;
	logic readFirst_reg;
	logic ptrWiper_reg;
	logic [IDX_W-1:0] ptr_reg;
	logic [IDX_W-1:0] rdIdx;
	logic [DATA_W-1:0] tx_reg;
	logic [DATA_W-1:0] wiper_reg;
	logic wp_reg;
	logic memPwr_reg;
	logic nvmWe_reg;
	logic [IDX_W-1:0] nvmIdx_reg;
	logic [DATA_W-1:0] nvmData_reg;
	logic [DATA_W-1:0] nvmRd;
	logic [DATA_W-1:0] nvmWiper;
	logic oe_reg;

	//--------------------------------------------------
	// Link clock domain
	//--------------------------------------------------

	// Each rising bus clock samples data and flips a toggle; the bit holds
	// for a whole bus clock, far longer than the core needs to see the toggle
	always_ff @(posedge sclClk) begin
		if (!nrst) begin
			linkTgl_reg <= 1'b0;
			linkBit_reg <= 1'b1;
		end else begin
			linkTgl_reg <= ~linkTgl_reg;
			linkBit_reg <= sdaIn;
		end
	end

	//--------------------------------------------------
	// Crossing and bus event detection
	//--------------------------------------------------

	dpc_sync #(
		.WIDTH(5),
		.RESET_VAL(SYNC_RST)
	) dpc_sync_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.asyncIn({sclClk, sdaIn, linkTgl_reg, strapAddrPinHigh, strapAddrPinLow}),
		.syncOut(syncVec)
	);

	assign sclS = syncVec[4];
	assign sdaS = syncVec[3];
	assign tglS = syncVec[2];

	// Previous filtered levels for edge detection
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sclPrev_reg <= SYNC_RST[4];
			sdaPrev_reg <= SYNC_RST[3];
			tglPrev_reg <= SYNC_RST[2];
		end else begin
			sclPrev_reg <= sclS;
			sdaPrev_reg <= sdaS;
			tglPrev_reg <= tglS;
		end
	end

	// Start and stop are data edges while the clock stays high
	assign ev.start = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
	assign ev.stop = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
	assign ev.bitStrobe = tglS != tglPrev_reg;
	assign ev.bitVal = linkBit_reg;
	assign ev.sclFall = sclPrev_reg && !sclS;

	//--------------------------------------------------
	// Strap capture
	//--------------------------------------------------

	function automatic logic [ADDR_W-1:0] addr_decode(input logic high, input logic low);
		case ({high, low})
			2'b00: addr_decode = TADDR_NONE;
			2'b10: addr_decode = TADDR_HIGH;
			2'b01: addr_decode = TADDR_LOW;
			default: addr_decode = TADDR_BOTH;
		endcase
	endfunction

	// Taken once after the synchroniser settles; later strap moves are ignored
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			settleCnt_reg <= '0;
			addrValid_reg <= 1'b0;
			targetAddr_reg <= TADDR_NONE;
		end else if (!addrValid_reg) begin
			settleCnt_reg <= settleCnt_reg + 3'h1;
			if (settleCnt_reg == STRAP_SETTLE) begin
				addrValid_reg <= 1'b1;
				targetAddr_reg <= addr_decode(syncVec[1], syncVec[0]);
			end
		end
	end

	//--------------------------------------------------
	// Byte framing
	//--------------------------------------------------

	assign byteDone = ev.bitStrobe && bitCnt_reg == BIT_LAST;
	assign ackSlot = ev.bitStrobe && bitCnt_reg == BIT_ACK;
	assign rxByte = {shift_reg[DATA_W-2:0], ev.bitVal};
	assign cmdNow = dpc_cmd_type'(rxByte[7:5]);
	assign instrDone = byteDone && state_reg == ST_INSTR;
	assign dataDone = byteDone && state_reg == ST_WDATA;
	assign addrMatch = addrValid_reg && rxByte[7:1] == targetAddr_reg;
	assign dataAccepted = cmd_reg == CMD_WIPER || cmd_reg == CMD_NVM || cmd_reg == CMD_PROTECT;

	// Nine slots per byte; a start realigns the count
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bitCnt_reg <= '0;
			shift_reg <= '0;
		end else if (ev.start) begin
			bitCnt_reg <= '0;
		end else if (ev.bitStrobe) begin
			bitCnt_reg <= (bitCnt_reg == BIT_ACK) ? 4'h0 : bitCnt_reg + 4'h1;
			shift_reg <= rxByte;
		end
	end

	// Frame sequencer; a repeated start always returns to address
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
		end else if (ev.start) begin
			state_reg <= ST_ADDR;
		end else if (ev.stop) begin
			state_reg <= ST_IDLE;
		end else if (byteDone) begin
			case (state_reg)
				ST_ADDR: state_reg <= !addrMatch ? ST_SKIP : rxByte[0] ? ST_READ : ST_INSTR;
				ST_INSTR: state_reg <= ST_WDATA;
				ST_WDATA: state_reg <= dataAccepted ? ST_WDATA : ST_SKIP;
				default: state_reg <= state_reg;
			endcase
		end else if (ackSlot && state_reg == ST_READ && !readFirst_reg && ev.bitVal) begin
			state_reg <= ST_SKIP;
		end
	end

	// Acknowledge owed for the byte just taken
	always_ff @(posedge core_clk) begin
		if (!nrst || ev.start || ev.stop) begin
			ackPend_reg <= 1'b0;
		end else if (byteDone) begin
			case (state_reg)
				ST_ADDR: ackPend_reg <= addrMatch;
				ST_INSTR: ackPend_reg <= 1'b1;
				ST_WDATA: ackPend_reg <= dataAccepted;
				default: ackPend_reg <= 1'b0;
			endcase
		end else if (ackSlot) begin
			ackPend_reg <= 1'b0;
		end
	end

	//--------------------------------------------------
	// Instruction and pointer
	//--------------------------------------------------

	// Command and index are held for the data bytes that follow
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			cmd_reg <= CMD_NOP;
			idx_reg <= WIPER_IDX;
		end else if (instrDone) begin
			cmd_reg <= cmdNow;
			idx_reg <= rxByte[IDX_W-1:0];
		end
	end

	// Pointer follows the last instruction that named a register
	assign rdIdx = (readFirst_reg || ptr_reg != TOL_FIRST) ? ptr_reg : TOL_LAST;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ptrWiper_reg <= 1'b1;
			ptr_reg <= WIPER_IDX;
		end else if (instrDone && cmdNow == CMD_WIPER) begin
			ptrWiper_reg <= 1'b1;
		end else if (instrDone && cmdNow == CMD_NVM) begin
			ptrWiper_reg <= 1'b0;
			ptr_reg <= rxByte[IDX_W-1:0];
		end else if (ackSlot && state_reg == ST_READ && !readFirst_reg && !ev.bitVal) begin
			ptr_reg <= rdIdx;
		end
	end

	// Read byte loaded at each acknowledge slot while reading
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			readFirst_reg <= 1'b0;
			tx_reg <= '0;
		end else if (byteDone && state_reg == ST_ADDR) begin
			readFirst_reg <= 1'b1;
		end else if (ackSlot && state_reg == ST_READ) begin
			readFirst_reg <= 1'b0;
			tx_reg <= ptrWiper_reg ? wiper_reg : nvmRd;
		end
	end

	//--------------------------------------------------
	// Wiper, protection and memory power
	//--------------------------------------------------

	// Restore is allowed under protection since it is not a host write
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wiper_reg <= MIDSCALE;
		end else if (instrDone && cmdNow == CMD_RESTORE) begin
			wiper_reg <= nvmWiper;
		end else if (dataDone && cmd_reg == CMD_WIPER && !wp_reg) begin
			wiper_reg <= rxByte;
		end
	end

	// Only the low data bit matters; upper bits are expected zero
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wp_reg <= 1'b0;
		end else if (dataDone && cmd_reg == CMD_PROTECT) begin
			wp_reg <= rxByte[0];
		end
	end

	// Any later command other than restore ends the memory-read power state
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			memPwr_reg <= 1'b0;
		end else if (instrDone) begin
			memPwr_reg <= cmdNow == CMD_RESTORE;
		end
	end

	// One-cycle write request into the store
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			nvmWe_reg <= 1'b0;
			nvmIdx_reg <= WIPER_IDX;
			nvmData_reg <= '0;
		end else if (instrDone && cmdNow == CMD_STORE && !wp_reg) begin
			nvmWe_reg <= 1'b1;
			nvmIdx_reg <= WIPER_IDX;
			nvmData_reg <= wiper_reg;
		end else if (dataDone && cmd_reg == CMD_NVM && !wp_reg) begin
			nvmWe_reg <= 1'b1;
			nvmIdx_reg <= idx_reg;
			nvmData_reg <= rxByte;
		end else begin
			nvmWe_reg <= 1'b0;
		end
	end

	dpc_nvm dpc_nvm_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.wrEn(nvmWe_reg),
		.wrIdx(nvmIdx_reg),
		.wrData(nvmData_reg),
		.rdIdx(rdIdx),
		.rdData(nvmRd),
		.wiperStore(nvmWiper)
	);

	//--------------------------------------------------
	// Data line drive
	//--------------------------------------------------

	// Changes only after a falling clock, so data is stable while clock is high
	always_ff @(posedge core_clk) begin
		if (!nrst || ev.start || ev.stop) begin
			oe_reg <= 1'b0;
		end else if (ev.sclFall) begin
			if (bitCnt_reg == BIT_ACK && ackPend_reg) begin
				oe_reg <= 1'b1;
			end else if (state_reg == ST_READ && !readFirst_reg && bitCnt_reg <= BIT_LAST) begin
				oe_reg <= ~tx_reg[3'(BIT_LAST - bitCnt_reg)];
			end else begin
				oe_reg <= 1'b0;
			end
		end
	end

	// Open drain: the pin is only ever pulled low
	assign sdaOut = 1'b0;
	assign sdaOe = oe_reg;
	assign wiperLatch = wiper_reg;
	assign writeProtect = wp_reg;
	assign memReadPower = memPwr_reg;
	assign targetAddr = targetAddr_reg;
	assign addrValid = addrValid_reg;

	//--------------------------------------------------
	// Checks
	//--------------------------------------------------

	// Capture must take the filtered strap levels of the capture cycle
	a_addr_table: assert property ($rose(addrValid_reg) |->
		targetAddr_reg == addr_decode($past(syncVec[1]), $past(syncVec[0])))
		else $error("address not from straps");
	a_strap_frozen: assert property (addrValid_reg && $past(addrValid_reg) |->
		$stable(targetAddr_reg))
		else $error("address moved after capture");
	a_ack_pull: assert property (ev.sclFall && bitCnt_reg == BIT_ACK && ackPend_reg &&
		!ev.start && !ev.stop |=> sdaOe)
		else $error("missing acknowledge");
	a_wiper_write: assert property (dataDone && cmd_reg == CMD_WIPER && !wp_reg |=>
		wiper_reg == $past(rxByte))
		else $error("wiper not written");
	a_protect_hold: assert property (dataDone && cmd_reg == CMD_WIPER && wp_reg |=>
		$stable(wiper_reg))
		else $error("protected wiper changed");
	a_protect_set: assert property (dataDone && cmd_reg == CMD_PROTECT |=>
		wp_reg == $past(rxByte[0]))
		else $error("protect flag wrong");
	a_restore_power: assert property (instrDone && cmdNow == CMD_RESTORE |=>
		memPwr_reg && wiper_reg == $past(nvmWiper))
		else $error("restore failed");
	a_nop_idle: assert property (instrDone && cmdNow == CMD_NOP |=> !memPwr_reg)
		else $error("power state kept after nop");
	// Write request must stay low in the very cycle after the instruction
	a_bad_cmd: assert property (instrDone &&
		(rxByte[7:5] == 3'h3 || rxByte[7:5] == 3'h7) |=>
		$stable(wiper_reg) && $stable(wp_reg) && !nvmWe_reg)
		else $error("undefined command acted");
	a_store_copy: assert property (instrDone && cmdNow == CMD_STORE && !wp_reg |=>
		nvmWe_reg && nvmIdx_reg == WIPER_IDX && nvmData_reg == $past(wiper_reg))
		else $error("store missing");
	a_tol_advance: assert property (ackSlot && state_reg == ST_READ &&
		!readFirst_reg && !ev.bitVal && ptr_reg == TOL_FIRST |=> ptr_reg == TOL_LAST)
		else $error("pointer not advanced");
	a_wp_powerup: assert property ($past(!nrst) |-> !wp_reg)
		else $error("protect set after reset");
endmodule
`default_nettype wire

/* hdl/dpc_nvm.sv */
`timescale 1ns/10ps
`default_nettype none
// Nonvolatile store model: wiper word, user words, read-only tolerance pair
module dpc_nvm #(
	parameter int DEPTH = dpc_pkg::NVM_DEPTH,
	parameter logic [7:0] TOL_INT = 8'h00,
	parameter logic [7:0] TOL_FRAC = 8'h00
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire logic [dpc_pkg::IDX_W-1:0] wrIdx,
	input wire logic [dpc_pkg::DATA_W-1:0] wrData,
	input wire logic [dpc_pkg::IDX_W-1:0] rdIdx,
	output logic [dpc_pkg::DATA_W-1:0] rdData,
	output logic [dpc_pkg::DATA_W-1:0] wiperStore
);
	import dpc_pkg::*;
	logic [DATA_W-1:0] mem [DEPTH];

	// Reset stands in for factory contents; tolerance words never take writes
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (IDX_W'(i) == TOL_FIRST) begin
					mem[i] <= TOL_INT;
				end else if (IDX_W'(i) == TOL_LAST) begin
					mem[i] <= TOL_FRAC;
				end else if (IDX_W'(i) == WIPER_IDX) begin
					mem[i] <= MIDSCALE;
				end else begin
					mem[i] <= '0;
				end
			end
		end else if (wrEn && wrIdx < TOL_FIRST) begin
			mem[wrIdx] <= wrData;
		end
	end

	// Combinational read ports
	assign rdData = mem[rdIdx];
	assign wiperStore = mem[WIPER_IDX];
endmodule
`default_nettype wire

/* hdl/dpc_pkg.sv */
package dpc_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int IDX_W = 5;
	localparam int NVM_DEPTH = 32;
	// Bus addresses, indexed by {high strap, low strap}
	localparam logic [ADDR_W-1:0] TADDR_NONE = 7'h18;
	localparam logic [ADDR_W-1:0] TADDR_HIGH = 7'h1A;
	localparam logic [ADDR_W-1:0] TADDR_LOW = 7'h4C;
	localparam logic [ADDR_W-1:0] TADDR_BOTH = 7'h4E;
	// Memory map and reset contents
	localparam logic [IDX_W-1:0] WIPER_IDX = 5'h00;
	localparam logic [IDX_W-1:0] TOL_FIRST = 5'h1E;
	localparam logic [IDX_W-1:0] TOL_LAST = 5'h1F;
	localparam logic [DATA_W-1:0] MIDSCALE = 8'h80;
	// Bit slots within a nine-clock byte
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	// Core cycles after reset before the straps are taken
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// Synchroniser idle value {scl, sda, toggle, strap high, strap low}
	localparam logic [4:0] SYNC_RST = 5'h18;

	typedef enum logic [2:0] {
		CMD_WIPER = 3'h0,
		CMD_NVM = 3'h1,
		CMD_PROTECT = 3'h2,
		CMD_NOP = 3'h4,
		CMD_RESTORE = 3'h5,
		CMD_STORE = 3'h6
	} dpc_cmd_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_INSTR = 3'h2,
		ST_WDATA = 3'h3,
		ST_READ = 3'h4,
		ST_SKIP = 3'h5
	} dpc_state_type;

	// Bus events seen in the core domain
	typedef struct packed {
		logic start;
		logic stop;
		logic bitStrobe;
		logic bitVal;
		logic sclFall;
	} dpc_link_type;
endpackage

/* hdl/dpc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; a bit changes only when stages two and three agree
module dpc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;

	// Stage one feeds stage two only, to give metastability a full cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stage1_reg <= RESET_VAL;
			stage2_reg <= RESET_VAL;
			stage3_reg <= RESET_VAL;
		end else begin
			stage1_reg <= asyncIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
		end
	end

	// Agreement filter rejects single-cycle glitches
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			syncOut <= RESET_VAL;
		end else begin
			syncOut <= (stage2_reg & stage3_reg) | (syncOut & (stage2_reg ^ stage3_reg));
		end
	end
endmodule
`default_nettype wire

/* tb/dpc_decoder_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module dpc_decoder_tb;
	import dpc_pkg::*;
	localparam logic [6:0] DEV = 7'h18;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic strapLow = 1'b0;
	logic strapHigh = 1'b0;
	logic sclClk, hostSda, sdaOut, sdaOe, writeProtect, memReadPower, addrValid;
	logic [DATA_W-1:0] wiperLatch;
	logic [ADDR_W-1:0] targetAddr;
	wire logic sdaBus;
	int errCount = 0;
	int comparisons = 0;

	// Open-drain wire with pull-up
	assign sdaBus = hostSda & (sdaOe ? sdaOut : 1'b1);

	// Core clock, 25 ns
	always #12.5 core_clk = ~core_clk;

	dpc_decoder dpc_decoder_inst (
		.core_clk(core_clk),
		.nrst(nrst),
		.sclClk(sclClk),
		.sdaIn(sdaBus),
		.strapAddrPinLow(strapLow),
		.strapAddrPinHigh(strapHigh),
		.sdaOut(sdaOut),
		.sdaOe(sdaOe),
		.wiperLatch(wiperLatch),
		.writeProtect(writeProtect),
		.memReadPower(memReadPower),
		.targetAddr(targetAddr),
		.addrValid(addrValid)
	);

	dpc_host dpc_host_inst (
		.sclClk(sclClk),
		.sdaDrv(hostSda),
		.sdaBus(sdaBus)
	);

	// -------------------------------
	// Helpers
	// -------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			errCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic testDone();
		if (errCount == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Straps settle before release; bus stays idle until capture
	task automatic resetDut(input logic hi, input logic lo);
		@(posedge core_clk);
		nrst <= 1'b0;
		strapHigh <= hi;
		strapLow <= lo;
		repeat (2) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (10) @(posedge core_clk);
		check(8'(addrValid), 8'h01);
	endtask

	// Write frame; n data bytes taken high byte first from d
	task automatic wrFrame(input logic [6:0] a, input logic aAck, input logic [7:0] ins,
		input logic [15:0] d, input int n, input logic dAck);
		logic ack;
		dpc_host_inst.busStart();
		dpc_host_inst.sendByte({a, 1'b0}, ack);
		check(8'(ack), 8'(aAck));
		dpc_host_inst.sendByte(ins, ack);
		check(8'(ack), 8'(aAck));
		for (int k = 0; k < n; k++) begin
			dpc_host_inst.sendByte(d[8*(n-1-k) +: 8], ack);
			check(8'(ack), 8'(dAck));
		end
		dpc_host_inst.busStop();
	endtask

	// Read frame with optional pointer setup; last byte not acknowledged
	task automatic rdFrame(input logic setup, input logic [7:0] ins, input logic [15:0] exp,
		input int n);
		logic ack;
		logic [7:0] d;
		if (setup) begin
			dpc_host_inst.busStart();
			dpc_host_inst.sendByte({DEV, 1'b0}, ack);
			dpc_host_inst.sendByte(ins, ack);
		end
		dpc_host_inst.busStart();
		dpc_host_inst.sendByte({DEV, 1'b1}, ack);
		check(8'(ack), 8'h01);
		for (int k = 0; k < n; k++) begin
			dpc_host_inst.readByte(k == n - 1, d);
			check(d, exp[8*(n-1-k) +: 8]);
		end
		dpc_host_inst.busStop();
	endtask

	// -------------------------------
	// Main sequence
	// -------------------------------
	initial begin
		logic [6:0] addrTab [4];
		addrTab = '{7'h18, 7'h4C, 7'h1A, 7'h4E};
		// Every strap pair, each answered at its own address
		for (int i = 3; i >= 0; i--) begin
			resetDut(i[1], i[0]);
			check(8'(targetAddr), 8'(addrTab[i]));
			wrFrame(addrTab[i], 1'b1, 8'h80, 16'h0000, 0, 1'b0);
		end
		check(8'(writeProtect), 8'h00);
		// Straps moved after capture must not move the address
		strapHigh <= 1'b1;
		repeat (20) @(posedge core_clk);
		check(8'(targetAddr), 8'h18);
		wrFrame(DEV, 1'b1, 8'h00, 16'h5AA5, 2, 1'b1);
		check(wiperLatch, 8'hA5);
		rdFrame(1'b0, 8'h00, 16'h00A5, 1);
		rdFrame(1'b1, 8'h00, 16'h00A5, 1);
		wrFrame(DEV, 1'b1, 8'h20, 16'h003C, 1, 1'b1);
		check(wiperLatch, 8'hA5);
		wrFrame(DEV, 1'b1, 8'h25, 16'h0077, 1, 1'b1);
		rdFrame(1'b0, 8'h00, 16'h0077, 1);
		rdFrame(1'b1, 8'h20, 16'h003C, 1);
		wrFrame(DEV, 1'b1, 8'hC0, 16'h0000, 0, 1'b0);
		rdFrame(1'b1, 8'h20, 16'h00A5, 1);
		wrFrame(DEV, 1'b1, 8'h00, 16'h0011, 1, 1'b1);
		wrFrame(DEV, 1'b1, 8'hA0, 16'h0000, 0, 1'b0);
		check(wiperLatch, 8'hA5);
		check(8'(memReadPower), 8'h01);
		wrFrame(DEV, 1'b1, 8'h80, 16'h0000, 0, 1'b0);
		check(8'(memReadPower), 8'h00);
		// Unlisted codes: data refused, nothing changes
		wrFrame(DEV, 1'b1, 8'h60, 16'h0033, 1, 1'b0);
		wrFrame(DEV, 1'b1, 8'hE0, 16'h0001, 1, 1'b0);
		check(wiperLatch, 8'hA5);
		check(8'(writeProtect), 8'h00);
		// Wiper now differs from the stored copy, so a leaked store would show
		wrFrame(DEV, 1'b1, 8'h00, 16'h0066, 1, 1'b1);
		check(wiperLatch, 8'h66);
		// Protection on: writes and store are swallowed
		wrFrame(DEV, 1'b1, 8'h40, 16'h0001, 1, 1'b1);
		check(8'(writeProtect), 8'h01);
		wrFrame(DEV, 1'b1, 8'h00, 16'h0022, 1, 1'b1);
		wrFrame(DEV, 1'b1, 8'h20, 16'h0044, 1, 1'b1);
		wrFrame(DEV, 1'b1, 8'hC0, 16'h0000, 0, 1'b0);
		check(wiperLatch, 8'h66);
		rdFrame(1'b1, 8'h20, 16'h00A5, 1);
		wrFrame(DEV, 1'b1, 8'h40, 16'h0000, 1, 1'b1);
		check(8'(writeProtect), 8'h00);
		wrFrame(DEV, 1'b1, 8'h40, 16'h0001, 1, 1'b1);
		resetDut(1'b0, 1'b0);
		check(8'(writeProtect), 8'h00);
		// Foreign address gets no acknowledge and no effect
		wrFrame(7'h4C, 1'b0, 8'h00, 16'h0099, 1, 1'b0);
		check(wiperLatch, 8'h80);
		rdFrame(1'b1, 8'h3E, 16'h0000, 2);
		testDone();
	end

	// Hang guard: about 81 bytes at 23 us each plus framing is near 2.0 ms
	initial begin
		#2_400_000;
		errCount++;
		testDone();
	end
endmodule
`default_nettype wire

/* tb/dpc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Bus controller model; clock stands high between frames
module dpc_host #(
	parameter int QTR = 640
) (
	output logic sclClk,
	output logic sdaDrv,
	input wire logic sdaBus
);
	// Idle bus: both lines released high
	initial begin
		sclClk = 1'b1;
		sdaDrv = 1'b1;
	end

	// -------------------------------
	// Conditions and single bits
	// -------------------------------
	// Start, or repeated start from mid-frame with clock low
	task automatic busStart();
		sdaDrv <= 1'b1;
		#QTR sclClk <= 1'b1;
		#QTR sdaDrv <= 1'b0;
		#QTR sclClk <= 1'b0;
	endtask

	// Data only changes while the clock is low
	task automatic bitOut(input logic b);
		sdaDrv <= b;
		#QTR sclClk <= 1'b1;
		#(2*QTR) sclClk <= 1'b0;
		#QTR;
	endtask

	// Stop: rising data with clock high
	task automatic busStop();
		sdaDrv <= 1'b0;
		#QTR sclClk <= 1'b1;
		#QTR sdaDrv <= 1'b1;
		#QTR;
	endtask

	// -------------------------------
	// Bytes
	// -------------------------------
	// Eight bits MSB first, then sample the ninth-clock acknowledge
	task automatic sendByte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitOut(d[i]);
		end
		sdaDrv <= 1'b1;
		#QTR sclClk <= 1'b1;
		#QTR ack = ~sdaBus;
		#QTR sclClk <= 1'b0;
		#QTR;
	endtask

	// Sample mid-high; device shifts its bits after each falling edge
	task automatic readByte(input logic noAck, output logic [7:0] d);
		sdaDrv <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			#QTR sclClk <= 1'b1;
			#QTR d[i] = sdaBus;
			#QTR sclClk <= 1'b0;
			#QTR;
		end
		bitOut(noAck);
	endtask
endmodule
`default_nettype wire
